// >>> hw/prp_pkg.sv
// Package for the paged address relocation and protection unit.
// Assumes a 16-bit virtual byte address and an 18-bit physical byte address.
package prp_pkg;
	// ------------------------------------------------------------
	// Address geometry
	// ------------------------------------------------------------
	localparam int VA_W       = 16;
	localparam int PA_W       = 18;
	localparam int PAGE_SEL_W = 3;
	localparam int PAGE_SEL_LO = 13;
	localparam int DISP_W     = 13;
	localparam int BASE_W     = 12;
	localparam int BASE_SHIFT = 6;
	localparam int LEN_W      = 7;
	localparam int BLOCK_LO   = 6;
	localparam int KEY_W      = 2;
	localparam int MODE_W     = 2;
	localparam int NUM_MODES  = 3;
	localparam int PAGES_PER_SPACE = 8;
	localparam int NUM_ENTRIES = NUM_MODES * 2 * PAGES_PER_SPACE;
	localparam int IDX_W      = 6;

	// ------------------------------------------------------------
	// Processor modes, as carried on the two status bits
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PRP_MODE_KERNEL     = 2'h0,
		PRP_MODE_SUPERVISOR = 2'h1,
		PRP_MODE_ILLEGAL    = 2'h2,
		PRP_MODE_USER       = 2'h3
	} prp_mode_e;

	// ------------------------------------------------------------
	// Page access keys
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PRP_KEY_NONRES    = 2'h0,
		PRP_KEY_READ_ONLY = 2'h1,
		PRP_KEY_EXEC_ONLY = 2'h2,
		PRP_KEY_READ_WRITE = 2'h3
	} prp_key_e;

	// Abort reason bit positions.
	localparam int ABT_NONRES = 0;
	localparam int ABT_RDONLY = 1;
	localparam int ABT_EXONLY = 2;
	localparam int ABT_LENGTH = 3;
	localparam int ABT_MODE   = 4;
	localparam int ABT_W      = 5;

	// Reset values of every page table entry.
	localparam logic [BASE_W-1:0] BASE_RST = 12'h000;
	localparam logic [LEN_W-1:0]  LEN_RST  = 7'h00;
	localparam logic [KEY_W-1:0]  KEY_RST  = 2'h0;
endpackage

// >>> hw/prp_key_check.sv
// Access key checker for one reference against one page descriptor.
// Assumes purely combinational use by the relocation unit on the same clock.
`timescale 1ns/10ps
`default_nettype none
module prp_key_check
	import prp_pkg::*;
(
	// Descriptor
	input  wire logic [KEY_W-1:0] key_in,
	input  wire logic [LEN_W-1:0] len_in,
	// Reference
	input  wire logic [LEN_W-1:0] block_in,
	input  wire logic             write_in,
	input  wire logic             istream_in,
	// Verdict
	output logic      [ABT_W-1:0] fault_out
);
	always_comb begin
		fault_out = '0;
		case (prp_key_e'(key_in))
			PRP_KEY_NONRES:     fault_out[ABT_NONRES] = 1'b1;
			PRP_KEY_READ_ONLY:  fault_out[ABT_RDONLY] = write_in;
			PRP_KEY_EXEC_ONLY:  fault_out[ABT_EXONLY] = ~istream_in | write_in;
			PRP_KEY_READ_WRITE: fault_out = '0;
			default:            fault_out[ABT_NONRES] = 1'b1;
		endcase
		// A page is length+1 blocks of 32 words, so 4096 words at most.
		if (block_in > len_in) begin
			fault_out[ABT_LENGTH] = 1'b1;
		end
	end
endmodule // prp_key_check
`default_nettype wire

// >>> hw/prp_unit.sv
// Paged address relocation and protection unit, top level.
// Assumes processor and memory share clk_in; every input is synchronous to it.
//
// Overview of operation
// - Every processor reference is intercepted and its memory address is the page base plus offset.
// - The physical address toward memory is 18 bits wide, covering 128K words.
// - A non-resident page refuses every read and every write.
// - A read-only page allows reads and blocks every write from reaching memory.
// - An execute-only page allows only instruction-stream reads and refuses all others.
// - Each processor mode has sixteen independently relocatable pages.
// - Each page length is a multiple of 32 words, up to 4096 words.
// - Each page base is any multiple of 32 words in the 128K-word space.
// - Each page keeps an accessed flag and a written flag, set by references and readable.
// - Instruction-stream and data references relocate through separate base sets.
// - Data references always use data-space bases, never instruction-space ones.
// - Kernel, supervisor and user modes each have their own page set, chosen by the mode.
// - The processor supplies the mode on two status bits which select the register set.
// - The top three virtual address bits index one of eight bases in the chosen subset.
// - A base register holds twelve bits; the low six physical bits of the base are zero.
// - The displacement added to the base is the low thirteen virtual address bits.
`timescale 1ns/10ps
`default_nettype none
module prp_unit
	import prp_pkg::*;
#(
	parameter int PAGES = PAGES_PER_SPACE
)(
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// Processor reference
	input  wire logic                  ref_req_in,
	input  wire logic [VA_W-1:0]       ref_vaddr_in,
	input  wire logic [MODE_W-1:0]     ref_mode_in,
	input  wire logic                  ref_write_in,
	input  wire logic                  ref_istream_in,
	// Memory side
	output logic                       mem_start_out,
	output logic      [PA_W-1:0]       mem_paddr_out,
	output logic                       mem_write_out,
	// Abort toward the processor
	output logic                       abort_out,
	output logic      [ABT_W-1:0]      abort_reason_out,
	// Page table programming
	input  wire logic                  cfg_write_in,
	input  wire logic [MODE_W-1:0]     cfg_mode_in,
	input  wire logic                  cfg_ispace_in,
	input  wire logic [PAGE_SEL_W-1:0] cfg_page_in,
	input  wire logic [BASE_W-1:0]     cfg_base_in,
	input  wire logic [LEN_W-1:0]      cfg_len_in,
	input  wire logic [KEY_W-1:0]      cfg_key_in,
	// Page table readback of the entry selected by the cfg index
	output logic      [BASE_W-1:0]     rd_base_out,
	output logic      [LEN_W-1:0]      rd_len_out,
	output logic      [KEY_W-1:0]      rd_key_out,
	output logic                       rd_accessed_out,
	output logic                       rd_written_out
);
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (PAGES != PAGES_PER_SPACE) begin : g_bad_pages
		$error("prp_unit: PAGES must equal the three-bit page select range");
	end

	// ------------------------------------------------------------
	// Page table storage
	// ------------------------------------------------------------
	logic [BASE_W-1:0] base_reg [NUM_ENTRIES];
	logic [BASE_W-1:0] base_next [NUM_ENTRIES];
	logic [LEN_W-1:0]  len_reg  [NUM_ENTRIES];
	logic [LEN_W-1:0]  len_next [NUM_ENTRIES];
	logic [KEY_W-1:0]  key_reg  [NUM_ENTRIES];
	logic [KEY_W-1:0]  key_next [NUM_ENTRIES];
	logic [NUM_ENTRIES-1:0] acc_reg;
	logic [NUM_ENTRIES-1:0] acc_next;
	logic [NUM_ENTRIES-1:0] wr_reg;
	logic [NUM_ENTRIES-1:0] wr_next;

	logic                  mem_start_reg;
	logic                  mem_start_next;
	logic [PA_W-1:0]       paddr_reg;
	logic [PA_W-1:0]       paddr_next;
	logic                  mem_write_reg;
	logic                  mem_write_next;
	logic                  abort_reg;
	logic                  abort_next;
	logic [ABT_W-1:0]      reason_reg;
	logic [ABT_W-1:0]      reason_next;

	// ------------------------------------------------------------
	// Entry selection
	// ------------------------------------------------------------
	function automatic logic [IDX_W-1:0] entry_index(input logic [MODE_W-1:0] mode,
		input logic ispace, input logic [PAGE_SEL_W-1:0] page);
		logic [1:0] set;
		set = (mode == PRP_MODE_USER) ? 2'h2 : mode;
		return {set, ~ispace, page};
	endfunction

	logic                  mode_bad;
	logic [PAGE_SEL_W-1:0] ref_page;
	logic [IDX_W-1:0]      ref_idx;
	logic [IDX_W-1:0]      cfg_idx;
	logic                  cfg_ok;
	logic [ABT_W-1:0]      key_fault;
	logic [ABT_W-1:0]      fault;

	assign mode_bad = (ref_mode_in == PRP_MODE_ILLEGAL);
	assign ref_page = ref_vaddr_in[PAGE_SEL_LO +: PAGE_SEL_W];
	// Instruction-stream references use I bases; all else uses D bases.
	assign ref_idx  = entry_index(ref_mode_in, ref_istream_in, ref_page);
	assign cfg_idx  = entry_index(cfg_mode_in, cfg_ispace_in, cfg_page_in);
	assign cfg_ok   = (cfg_mode_in != PRP_MODE_ILLEGAL);

	prp_key_check u_key_check (
		.key_in     (mode_bad ? KEY_RST : key_reg[ref_idx]),
		.len_in     (mode_bad ? LEN_RST : len_reg[ref_idx]),
		.block_in   (ref_vaddr_in[BLOCK_LO +: LEN_W]),
		.write_in   (ref_write_in),
		.istream_in (ref_istream_in),
		.fault_out  (key_fault)
	);

	always_comb begin
		fault = key_fault;
		fault[ABT_MODE] = mode_bad;
		if (mode_bad) begin
			fault[ABT_NONRES] = 1'b0;
			fault[ABT_LENGTH] = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Next-state computation
	// ------------------------------------------------------------
	always_comb begin
		base_next      = base_reg;
		len_next       = len_reg;
		key_next       = key_reg;
		acc_next       = acc_reg;
		wr_next        = wr_reg;
		mem_start_next = 1'b0;
		mem_write_next = mem_write_reg;
		paddr_next     = paddr_reg;
		abort_next     = 1'b0;
		reason_next    = reason_reg;

		// Rewriting a descriptor starts the page's history afresh.
		if (cfg_write_in && cfg_ok) begin
			base_next[cfg_idx] = cfg_base_in;
			len_next[cfg_idx]  = cfg_len_in;
			key_next[cfg_idx]  = cfg_key_in;
			acc_next[cfg_idx]  = 1'b0;
			wr_next[cfg_idx]   = 1'b0;
		end

		if (ref_req_in) begin
			if (fault != '0) begin
				// No memory cycle starts for a refused reference.
				abort_next  = 1'b1;
				reason_next = fault;
			end else begin
				mem_start_next = 1'b1;
				mem_write_next = ref_write_in;
				// Base with six implied zeros plus the 13-bit displacement.
				paddr_next = {base_reg[ref_idx], BASE_SHIFT'(0)}
					+ PA_W'(ref_vaddr_in[DISP_W-1:0]);
				// Flags are set after the clear so a same-cycle reference wins.
				acc_next[ref_idx] = 1'b1;
				if (ref_write_in) begin
					wr_next[ref_idx] = 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NUM_ENTRIES; i++) begin
				base_reg[i] <= BASE_RST;
				len_reg[i]  <= LEN_RST;
				key_reg[i]  <= KEY_RST;
			end
			acc_reg       <= '0;
			wr_reg        <= '0;
			mem_start_reg <= 1'b0;
			mem_write_reg <= 1'b0;
			paddr_reg     <= '0;
			abort_reg     <= 1'b0;
			reason_reg    <= '0;
		end else begin
			base_reg      <= base_next;
			len_reg       <= len_next;
			key_reg       <= key_next;
			acc_reg       <= acc_next;
			wr_reg        <= wr_next;
			mem_start_reg <= mem_start_next;
			mem_write_reg <= mem_write_next;
			paddr_reg     <= paddr_next;
			abort_reg     <= abort_next;
			reason_reg    <= reason_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign mem_start_out    = mem_start_reg;
	assign mem_paddr_out    = paddr_reg;
	assign mem_write_out    = mem_write_reg;
	assign abort_out        = abort_reg;
	assign abort_reason_out = reason_reg;
	assign rd_base_out      = cfg_ok ? base_reg[cfg_idx] : BASE_RST;
	assign rd_len_out       = cfg_ok ? len_reg[cfg_idx] : LEN_RST;
	assign rd_key_out       = cfg_ok ? key_reg[cfg_idx] : KEY_RST;
	assign rd_accessed_out  = cfg_ok & acc_reg[cfg_idx];
	assign rd_written_out   = cfg_ok & wr_reg[cfg_idx];
endmodule // prp_unit
`default_nettype wire

// >>> test/prp_unit_sva.sv
// Port-level checker for the paged relocation unit.
// Assumes one clock domain; bound to prp_unit from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module prp_unit_sva
	import prp_pkg::*;
(
	// Clock, reset and reference
	input wire logic                  clk_in,
	input wire logic                  rst_in,
	input wire logic                  ref_req_in,
	input wire logic [VA_W-1:0]       ref_vaddr_in,
	input wire logic [MODE_W-1:0]     ref_mode_in,
	input wire logic                  ref_write_in,
	input wire logic                  ref_istream_in,
	// Answers
	input wire logic                  mem_start_out,
	input wire logic [PA_W-1:0]       mem_paddr_out,
	input wire logic                  abort_out,
	input wire logic [ABT_W-1:0]      abort_reason_out,
	// Table select and readback
	input wire logic                  cfg_write_in,
	input wire logic [MODE_W-1:0]     cfg_mode_in,
	input wire logic                  cfg_ispace_in,
	input wire logic [PAGE_SEL_W-1:0] cfg_page_in,
	input wire logic [BASE_W-1:0]     rd_base_out,
	input wire logic [LEN_W-1:0]      rd_len_out,
	input wire logic [KEY_W-1:0]      rd_key_out,
	input wire logic                  rd_accessed_out
);
	// The readback shows the referenced entry only when the cfg index points at it.
	logic [PA_W-1:0] exp_pa_reg;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			exp_pa_reg <= '0;
		else
			exp_pa_reg <= {rd_base_out, 6'h00} + PA_W'(ref_vaddr_in[DISP_W-1:0]);
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_hit;
		ref_req_in && !cfg_write_in && ref_mode_in != 2'h2 && cfg_mode_in == ref_mode_in
			&& cfg_ispace_in == ref_istream_in && cfg_page_in == ref_vaddr_in[15:13];
	endsequence
	sequence s_grant;
		s_hit ##0 (rd_key_out == 2'h3 && ref_vaddr_in[12:6] <= rd_len_out);
	endsequence
	AST_ANSWER: assert property (ref_req_in |=> mem_start_out != abort_out)
		else $error("reference not answered by exactly one pulse");
	AST_QUIET: assert property (!ref_req_in |=> !mem_start_out && !abort_out)
		else $error("pulse without reference");
	AST_MODE: assert property (ref_req_in && ref_mode_in == 2'h2 |=> abort_out && abort_reason_out[ABT_MODE])
		else $error("illegal mode not refused");
	AST_NONRES: assert property (s_hit ##0 rd_key_out == 2'h0 |=> abort_out && abort_reason_out[ABT_NONRES])
		else $error("absent page not refused");
	AST_RDONLY: assert property (s_hit ##0 (rd_key_out == 2'h1 && ref_write_in) |=> abort_out && abort_reason_out[ABT_RDONLY])
		else $error("write to read-only page not refused");
	AST_EXONLY: assert property (s_hit ##0 (rd_key_out == 2'h2 && !ref_istream_in) |=> abort_out && abort_reason_out[ABT_EXONLY])
		else $error("data use of execute-only page not refused");
	AST_LENGTH: assert property (s_hit ##0 (ref_vaddr_in[12:6] > rd_len_out) |=> abort_out && abort_reason_out[ABT_LENGTH])
		else $error("reference past page end not refused");
	AST_RELOC: assert property (s_grant |=> mem_start_out && mem_paddr_out == exp_pa_reg)
		else $error("wrong physical address");
	AST_FLAG: assert property (s_grant ##1 ($stable(cfg_page_in) && $stable(cfg_mode_in)
		&& $stable(cfg_ispace_in)) |-> rd_accessed_out)
		else $error("accessed flag not set");
endmodule // prp_unit_sva
`default_nettype wire

// >>> test/prp_mem_model.sv
// Memory model at the far side: counts the cycles that reach it.
// Assumes the unit's start pulse lasts one clock.
`timescale 1ns/10ps
`default_nettype none
module prp_mem_model
	import prp_pkg::*;
(
	input wire logic            clk_in,
	input wire logic            mem_start_in,
	input wire logic [PA_W-1:0] mem_paddr_in,
	input wire logic            mem_write_in
);
	int              n_cycles = 0;
	int              n_writes = 0;
	logic [PA_W-1:0] last_addr = '0;
	always @(posedge clk_in) begin
		if (mem_start_in === 1'b1) begin
			n_cycles <= n_cycles + 1;
			n_writes <= n_writes + int'(mem_write_in === 1'b1);
			last_addr <= mem_paddr_in;
		end
	end
endmodule // prp_mem_model
`default_nettype wire

// >>> test/prp_unit_tb.sv
// Self-checking bench for the relocation unit with a memory model.
// Assumes inputs change 1 ns after each rising edge.
`timescale 1ns/10ps
`default_nettype none
module prp_unit_tb;
	import prp_pkg::*;
	logic clk_in = 0, rst_in = 1, ref_req_in = 0, ref_write_in = 0, ref_istream_in = 0;
	logic cfg_write_in = 0, cfg_ispace_in = 0, mem_start_out, mem_write_out, abort_out;
	logic rd_accessed_out, rd_written_out;
	logic [VA_W-1:0] ref_vaddr_in = '0;
	logic [1:0] ref_mode_in = '0, cfg_mode_in = '0, cfg_key_in = '0, rd_key_out;
	logic [2:0] cfg_page_in = '0;
	logic [11:0] cfg_base_in = '0, rd_base_out;
	logic [6:0] cfg_len_in = '0, rd_len_out;
	logic [PA_W-1:0] mem_paddr_out;
	logic [ABT_W-1:0] abort_reason_out;
	int n_mismatch = 0, checks_done = 0;
	prp_unit prp_unit_i (.clk_in, .rst_in, .ref_req_in, .ref_vaddr_in, .ref_mode_in,
		.ref_write_in, .ref_istream_in, .mem_start_out, .mem_paddr_out, .mem_write_out,
		.abort_out, .abort_reason_out, .cfg_write_in, .cfg_mode_in, .cfg_ispace_in,
		.cfg_page_in, .cfg_base_in, .cfg_len_in, .cfg_key_in, .rd_base_out, .rd_len_out,
		.rd_key_out, .rd_accessed_out, .rd_written_out);
	prp_mem_model prp_mem_model_i (.clk_in, .mem_start_in(mem_start_out),
		.mem_paddr_in(mem_paddr_out), .mem_write_in(mem_write_out));
	initial forever #5 clk_in = ~clk_in;
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [PA_W-1:0] got, input logic [PA_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One idle edge between transfers, so no strobe is lowered and raised in one step.
	task automatic gap;
		@(posedge clk_in);
		#1;
	endtask
	task automatic cfg(input logic [1:0] m, input logic i, input logic [2:0] p,
		input logic [11:0] b, input logic [6:0] l, input logic [1:0] k);
		{cfg_mode_in, cfg_ispace_in, cfg_page_in, cfg_base_in, cfg_len_in, cfg_key_in} =
			{m, i, p, b, l, k};
		cfg_write_in = 1;
		@(posedge clk_in);
		#1 cfg_write_in = 0;
		gap();
	endtask
	// Mode arrives with each reference on two status bits.
	task automatic rf(input logic [15:0] va, input logic [1:0] m, input logic w, input logic i);
		{ref_vaddr_in, ref_mode_in, ref_write_in, ref_istream_in} = {va, m, w, i};
		ref_req_in = 1;
		@(posedge clk_in);
		#1 ref_req_in = 0;
	endtask
	task automatic grant(input logic [15:0] va, input logic [1:0] m, input logic w,
		input logic i, input logic [PA_W-1:0] pa);
		rf(va, m, w, i);
		chk(mem_start_out, 1'b1);
		chk(mem_paddr_out, pa);
		gap();
	endtask
	task automatic deny(input logic [15:0] va, input logic [1:0] m, input logic w,
		input logic i, input logic [ABT_W-1:0] why);
		rf(va, m, w, i);
		chk(abort_out, 1'b1);
		chk(abort_reason_out & why, why);
		gap();
	endtask
	task automatic t_reset;
		chk(PA_W'(rd_base_out), '0);
		chk(PA_W'({rd_len_out, rd_key_out, rd_accessed_out, rd_written_out}), '0);
		deny(16'h0000, 2'h0, 1'b0, 1'b0, 5'h01);
		$display("t_reset done");
	endtask
	task automatic t_reloc;
		logic [1:0] m;
		logic [11:0] b;
		for (int j = 0; j < 3; j++) begin
			m = (j == 2) ? 2'h3 : 2'(j);
			b = 12'hff0 + 12'(j);
			cfg(m, 1'b1, 3'h5, ~b, 7'h7f, 2'h3);
			cfg(m, 1'b0, 3'h5, b, 7'h7f, 2'h3);
			chk(rd_written_out, 1'b0);
			chk(PA_W'(rd_base_out), PA_W'(b));
			chk(PA_W'({rd_len_out, rd_key_out}), 18'h001ff);
			grant(16'hbfff, m, 1'b1, 1'b0, {b, 6'h00} + 18'h1fff);
			chk(rd_accessed_out & rd_written_out, 1'b1);
			grant(16'hbfff, m, 1'b0, 1'b1, {~b, 6'h00} + 18'h1fff);
		end
		// The illegal mode indexes the user entries: its write is dropped and user pages survive.
		cfg(2'h2, 1'b0, 3'h5, 12'h000, 7'h00, 2'h0);
		chk(PA_W'({rd_base_out, rd_key_out}), '0);
		grant(16'hbfff, 2'h3, 1'b0, 1'b0, {12'hff2, 6'h00} + 18'h1fff);
		grant(16'hbfff, 2'h0, 1'b0, 1'b0, {12'hff0, 6'h00} + 18'h1fff);
		$display("t_reloc done");
	endtask
	task automatic t_keys;
		int n0;
		cfg(2'h0, 1'b0, 3'h2, 12'h010, 7'h00, 2'h1);
		n0 = prp_mem_model_i.n_cycles;
		grant(16'h403e, 2'h0, 1'b0, 1'b0, 18'h0043e);
		deny(16'h4040, 2'h0, 1'b0, 1'b0, 5'h08);
		deny(16'h4000, 2'h0, 1'b1, 1'b0, 5'h02);
		cfg(2'h3, 1'b0, 3'h3, 12'h020, 7'h7f, 2'h2);
		deny(16'h6000, 2'h3, 1'b0, 1'b0, 5'h04);
		cfg(2'h3, 1'b1, 3'h3, 12'h020, 7'h7f, 2'h2);
		grant(16'h6002, 2'h3, 1'b0, 1'b1, 18'h00802);
		deny(16'h6002, 2'h2, 1'b0, 1'b1, 5'h10);
		@(posedge clk_in);
		#1 chk(18'(prp_mem_model_i.n_cycles - n0), 18'h2);
		chk(prp_mem_model_i.last_addr, 18'h00802);
		$display("t_keys done");
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		#1 rst_in = 0;
		t_reset();
		t_reloc();
		t_keys();
		chk(18'(prp_mem_model_i.n_writes), 18'h3);
		test_done();
	end
	initial begin
		#100000;
		n_mismatch++;
		test_done();
	end
endmodule // prp_unit_tb
bind prp_unit prp_unit_sva prp_unit_sva_i (.clk_in, .rst_in, .ref_req_in, .ref_vaddr_in,
	.ref_mode_in, .ref_write_in, .ref_istream_in, .mem_start_out, .mem_paddr_out, .abort_out,
	.abort_reason_out, .cfg_write_in, .cfg_mode_in, .cfg_ispace_in, .cfg_page_in,
	.rd_base_out, .rd_len_out, .rd_key_out, .rd_accessed_out);
`default_nettype wire
